// ### logic/rv_pkg.sv
// Purpose: Shared constants and types for the regulator serial register file.
// Assumes: One 10 MHz clock; serial pins sampled as synchronous inputs.
// Notes:   Offsets, reset values and timing counts live here only.
`default_nettype none
package rv_pkg;
    // Fixed target address on the serial bus; no pin or register alters it.
    localparam logic [6:0] RV_DEV_ADDR     = 7'h70;

    // Command codes that select a register.
    localparam logic [7:0] RV_CMD_CEIL     = 8'h02;
    localparam logic [7:0] RV_CMD_FLAGS    = 8'h04;
    localparam logic [7:0] RV_CMD_MASK     = 8'h05;
    localparam logic [7:0] RV_CMD_RAMP     = 8'h06;
    localparam logic [7:0] RV_CMD_TARGET   = 8'h07;
    localparam logic [7:0] RV_CMD_CURR     = 8'h08;

    // Reset values.
    localparam logic [7:0] RV_CEIL_RST     = 8'h51;
    localparam logic [7:0] RV_MASK_RST     = 8'h00;
    localparam logic [7:0] RV_RAMP_RST     = 8'h04;
    localparam logic [7:0] RV_TARGET_RST   = 8'h33;
    localparam logic [7:0] RV_ZERO_BYTE    = 8'h00;

    // Ceiling code limits: 10 mV steps, code 01 is 0.510 V and 7E is 1.76 V.
    localparam logic [7:0] RV_CEIL_MIN     = 8'h01;
    localparam logic [7:0] RV_CEIL_MAX     = 8'h7E;

    // Flag register layout.
    localparam int unsigned RV_BIT_HOT     = 5;
    localparam int unsigned RV_BIT_LOW     = 4;
    localparam int unsigned RV_BIT_HIGH    = 3;
    localparam int unsigned RV_BIT_EXCESS  = 2;
    localparam int unsigned RV_BIT_CEILV   = 1;
    localparam int unsigned RV_BIT_SUM     = 0;
    localparam logic [7:0] RV_MASK_USED    = 8'h3E;

    // Timing, in printed units, and cycle counts derived from the clock period.
    localparam int unsigned RV_CLK_PERIOD_NS = 100;
    localparam int unsigned RV_START_DLY_NS  = 500;
    localparam int unsigned RV_LOW_HOLD_US   = 200;
    localparam int unsigned RV_MON_PERIOD_US = 400;
    localparam logic [11:0] RV_START_CYC =
        12'((RV_START_DLY_NS + RV_CLK_PERIOD_NS - 1) / RV_CLK_PERIOD_NS);
    localparam logic [11:0] RV_LOW_HOLD_CYC =
        12'((RV_LOW_HOLD_US * 1000 + RV_CLK_PERIOD_NS - 1) / RV_CLK_PERIOD_NS);
    localparam logic [11:0] RV_MON_CYC =
        12'((RV_MON_PERIOD_US * 1000) / RV_CLK_PERIOD_NS);

    localparam logic [3:0] RV_BYTE_BITS    = 4'h8;

    // Fault and alarm conditions reported by the analog side.
    typedef struct packed {
        logic hot;     // Temperature sense below threshold.
        logic low;     // Output 200 mV or more below target.
        logic high;    // Output overvoltage condition.
        logic excess;  // Output overcurrent condition.
    } rv_fault_type;

    // Bus events decoded from the sampled serial pins.
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } rv_bus_ev_type;

    typedef enum logic [3:0] {
        RV_IDLE, RV_ADDR, RV_ACK_A, RV_CMD, RV_ACK_C,
        RV_WDATA, RV_ACK_D, RV_RDATA, RV_RACK, RV_SKIP
    } rv_state_type;
endpackage
`default_nettype wire

// ### logic/rv_i2c_edge.sv
// Purpose: Turns sampled serial clock and data into start, stop and edge events.
// Assumes: Pins are synchronous to clock and slower than a third of its rate.
// Notes:   Combinational events are valid for one cycle each.
`timescale 1ns/100ps
`default_nettype none
module rv_i2c_edge (
    input  wire logic              clock,   // System clock.
    input  wire logic              rst,     // Synchronous reset, active high.
    input  wire logic              scl,     // Serial clock pin level.
    input  wire logic              sda_in,  // Serial data pin level.
    output rv_pkg::rv_bus_ev_type  ev       // Decoded bus events.
);
    logic scl_prev_r;
    logic sda_prev_r;

    // Previous levels; reset to the idle-high bus so no false edge follows reset.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end
        else
        begin
            scl_prev_r <= scl;
            sda_prev_r <= sda_in;
        end
    end

    // Data changing while the clock is high marks start or stop.
    always_comb
    begin
        ev.start = scl & scl_prev_r & sda_prev_r & ~sda_in;
        ev.stop  = scl & scl_prev_r & ~sda_prev_r & sda_in;
        ev.rise  = scl & ~scl_prev_r;
        ev.fall  = ~scl & scl_prev_r;
        ev.sda   = sda_in;
    end
endmodule
`default_nettype wire

// ### logic/rv_regfile.sv
// Purpose: Serial-bus target register file of a step-down regulator controller.
// Assumes: Serial pins synchronous to a 10 MHz clock; analog side supplies flags.
// Notes:   Single-byte writes and single-byte repeated-start reads only.
// Function
// R1 - Answer only at the fixed address 70h.
// R2 - Serial transfers up to high-speed rate, never above 3.4 MHz; here the pins must run slower than a third of the 10 MHz clock.
// R3 - Ceiling register is read/write, resets to 51h (1.3 V).
// R4 - Ceiling code limited to the 0.510 V to 1.76 V range.
// R5 - Oversized target is acknowledged but ramps only to the ceiling.
// R6 - Flags: hot D5, low D4, high D3, excess D2, ceiling D1, summary D0.
// R7 - Flag bits D7 and D6 always read zero.
// R8 - Each flag sets on its condition regardless of the mask.
// R9 - Mask bit blocks that flag from the alert; mask resets to zero.
// R10 - Summary bit set when any unmasked flag is active; here the excess term uses the live condition, not the sticky D2 flag.
// R11 - Ramp-rate register read/write, sets slew, resets to 04h.
// R12 - Target write starts ramp 0.5 us after acknowledge; resets to 33h.
// R13 - Current register read-only, average current, refreshed every 400 us.
// R14 - Hot flag set while temperature sense is below threshold.
// R15 - Low flag set after output stays low for 200 us.
// R16 - Ceiling step is 10 mV; its top bit reads back zero.
// R17 - Ceiling flag set when target exceeds ceiling, clears when rewritten lower.
// R18 - Excess flag sticky until read after condition ends; no lasting alert.
// R19 - Alert is active low, open drain, released in normal operation.
// R20 - Write is address, command, data; read is command then repeated start.
// R21 - Reserved or read-only writes ignored; reserved reads return zero.
`timescale 1ns/100ps
`default_nettype none
module rv_regfile (
    input  wire logic                 clock,          // System clock, 10 MHz.
    input  wire logic                 rst,            // Synchronous reset, active high.
    input  wire logic                 scl,            // Serial clock pin.
    input  wire logic                 sda_in,         // Serial data pin level.
    output logic                      sda_out,        // Serial data drive value, always 0.
    output logic                      sda_oe_n,       // Serial data enable, low drives.
    input  wire rv_pkg::rv_fault_type fault_in,       // Analog fault conditions.
    input  wire logic [7:0]           current_sample, // Averaged current from the converter.
    output logic                      alert_out,      // Alert drive value, always 0.
    output logic                      alert_oe_n,     // Alert enable, low pulls the pin low.
    output logic [7:0]                vout_code,      // Applied output code after clamp.
    output logic [7:0]                ramp_rate,      // Slew setting to the ramp generator.
    output logic                      ramp_start      // One-cycle pulse starting a ramp.
);
    rv_pkg::rv_bus_ev_type ev;
    rv_pkg::rv_state_type  state_r;
    logic [3:0]  cnt_r;
    logic [7:0]  sh_r;
    logic [7:0]  tx_r;
    logic        rw_r;
    logic [7:0]  cmd_r;
    logic [6:0]  ceil_r;
    logic [7:0]  mask_r;
    logic [7:0]  target_r;
    logic [7:0]  ramp_r;
    logic [7:0]  curr_r;
    logic        excess_r;
    logic        low_flag_r;
    logic [11:0] low_cnt_r;
    logic [11:0] mon_cnt_r;
    logic [11:0] dly_cnt_r;
    logic        dly_busy_r;
    logic        byte_done;
    logic        wr_now;
    logic        rd_load;
    logic        ceil_viol;
    logic [5:1]  alert_terms;
    logic        summary;
    logic [7:0]  flags;
    logic [7:0]  rd_data;

    // Smaller of two codes; used for the ceiling limit and the target clamp.
    function automatic logic [7:0] rv_min(input logic [7:0] a, input logic [7:0] b);
        rv_min = (a < b) ? a : b;
    endfunction

    rv_i2c_edge u_edge ( // [R2]
        .clock  (clock),
        .rst    (rst),
        .scl    (scl),
        .sda_in (sda_in),
        .ev     (ev)
    );

    assign byte_done = (cnt_r == rv_pkg::RV_BYTE_BITS);
    assign wr_now    = (state_r == rv_pkg::RV_WDATA) && ev.fall && byte_done;
    assign rd_load   = (state_r == rv_pkg::RV_ACK_A) && ev.fall && rw_r;

    // Live flag image; the unused top bits stay zero.
    always_comb
    begin
        ceil_viol   = target_r > {1'b0, ceil_r};                         // [R17]
        alert_terms = {fault_in.hot, low_flag_r, fault_in.high,
                       fault_in.excess, ceil_viol} & ~mask_r[5:1];       // [R9] [R18]
        summary     = |alert_terms;                                      // [R10]
        flags                       = rv_pkg::RV_ZERO_BYTE;              // [R7]
        flags[rv_pkg::RV_BIT_HOT]    = fault_in.hot;                     // [R6] [R14] [R8]
        flags[rv_pkg::RV_BIT_LOW]    = low_flag_r;                       // [R6]
        flags[rv_pkg::RV_BIT_HIGH]   = fault_in.high;                    // [R6]
        flags[rv_pkg::RV_BIT_EXCESS] = excess_r;                         // [R6]
        flags[rv_pkg::RV_BIT_CEILV]  = ceil_viol;                        // [R6]
        flags[rv_pkg::RV_BIT_SUM]    = summary;                          // [R6]
    end

    // Read multiplexer; reserved codes answer zero.
    always_comb
    begin
        if (cmd_r == rv_pkg::RV_CMD_CEIL)
            rd_data = {1'b0, ceil_r};                                    // [R16]
        else if (cmd_r == rv_pkg::RV_CMD_FLAGS)
            rd_data = flags;
        else if (cmd_r == rv_pkg::RV_CMD_MASK)
            rd_data = mask_r;
        else if (cmd_r == rv_pkg::RV_CMD_RAMP)
            rd_data = ramp_r;
        else if (cmd_r == rv_pkg::RV_CMD_TARGET)
            rd_data = target_r;
        else if (cmd_r == rv_pkg::RV_CMD_CURR)
            rd_data = curr_r;
        else
            rd_data = rv_pkg::RV_ZERO_BYTE;                              // [R21]
    end

    // Protocol engine. Bits are sampled on clock rise and driven after clock fall,
    // so data never changes while the master's clock is high.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r  <= rv_pkg::RV_IDLE;
            cnt_r    <= '0;
            sh_r     <= '0;
            tx_r     <= '0;
            rw_r     <= 1'b0;
            cmd_r    <= '0;
            sda_oe_n <= 1'b1;
        end
        else if (ev.start)
        begin
            state_r  <= rv_pkg::RV_ADDR;                                 // [R20]
            cnt_r    <= '0;
            sda_oe_n <= 1'b1;
        end
        else if (ev.stop)
        begin
            state_r  <= rv_pkg::RV_IDLE;
            sda_oe_n <= 1'b1;
        end
        else if (ev.rise)
        begin
            sh_r  <= {sh_r[6:0], ev.sda};
            cnt_r <= cnt_r + 4'h1;
        end
        else if (ev.fall)
        begin
            case (state_r)
                rv_pkg::RV_ADDR:
                    if (byte_done)
                    begin
                        if (sh_r[7:1] == rv_pkg::RV_DEV_ADDR)            // [R1]
                        begin
                            rw_r     <= sh_r[0];
                            sda_oe_n <= 1'b0;
                            state_r  <= rv_pkg::RV_ACK_A;
                        end
                        else
                            state_r <= rv_pkg::RV_SKIP;
                    end
                rv_pkg::RV_ACK_A:
                begin
                    cnt_r <= '0;
                    if (rw_r)
                    begin
                        tx_r     <= rd_data;                             // [R20]
                        sda_oe_n <= rd_data[7];
                        state_r  <= rv_pkg::RV_RDATA;
                    end
                    else
                    begin
                        sda_oe_n <= 1'b1;
                        state_r  <= rv_pkg::RV_CMD;
                    end
                end
                rv_pkg::RV_CMD:
                    if (byte_done)
                    begin
                        cmd_r    <= sh_r;
                        sda_oe_n <= 1'b0;
                        state_r  <= rv_pkg::RV_ACK_C;
                    end
                rv_pkg::RV_ACK_C:
                begin
                    cnt_r    <= '0;
                    sda_oe_n <= 1'b1;
                    state_r  <= rv_pkg::RV_WDATA;
                end
                rv_pkg::RV_WDATA:
                    if (byte_done)
                    begin
                        sda_oe_n <= 1'b0;                                // [R5]
                        state_r  <= rv_pkg::RV_ACK_D;
                    end
                rv_pkg::RV_ACK_D:
                begin
                    sda_oe_n <= 1'b1;
                    state_r  <= rv_pkg::RV_SKIP;                         // [R20]
                end
                rv_pkg::RV_RDATA:
                    if (byte_done)
                    begin
                        sda_oe_n <= 1'b1;
                        state_r  <= rv_pkg::RV_RACK;
                    end
                    else
                    begin
                        tx_r     <= {tx_r[6:0], 1'b0};
                        sda_oe_n <= tx_r[6];
                    end
                rv_pkg::RV_RACK:
                    state_r <= rv_pkg::RV_SKIP;
                default:
                    state_r <= state_r;
            endcase
        end
    end

    // Writable registers; read-only and reserved codes fall through untouched.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ceil_r   <= rv_pkg::RV_CEIL_RST[6:0];                        // [R3]
            mask_r   <= rv_pkg::RV_MASK_RST;                             // [R9]
            ramp_r   <= rv_pkg::RV_RAMP_RST;                             // [R11]
            target_r <= rv_pkg::RV_TARGET_RST;                           // [R12]
        end
        else if (wr_now)
        begin
            if (cmd_r == rv_pkg::RV_CMD_CEIL)
                ceil_r <= 7'(rv_min(rv_pkg::RV_CEIL_MAX,
                                    (sh_r < rv_pkg::RV_CEIL_MIN) ? rv_pkg::RV_CEIL_MIN
                                                                 : sh_r)); // [R4] [R16]
            else if (cmd_r == rv_pkg::RV_CMD_MASK)
                mask_r <= sh_r & rv_pkg::RV_MASK_USED;
            else if (cmd_r == rv_pkg::RV_CMD_RAMP)
                ramp_r <= sh_r;
            else if (cmd_r == rv_pkg::RV_CMD_TARGET)
                target_r <= sh_r;                                        // [R17]
        end
    end

    // Delay from the data acknowledge to the ramp start, then apply the clamped code.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dly_busy_r <= 1'b0;
            dly_cnt_r  <= '0;
            ramp_start <= 1'b0;
            vout_code  <= rv_pkg::RV_TARGET_RST;
        end
        else
        begin
            ramp_start <= 1'b0;
            if (wr_now && (cmd_r == rv_pkg::RV_CMD_TARGET))
            begin
                dly_busy_r <= 1'b1;                                      // [R12]
                dly_cnt_r  <= '0;
            end
            else if (dly_busy_r)
            begin
                dly_cnt_r <= dly_cnt_r + 12'h001;
                if (dly_cnt_r == rv_pkg::RV_START_CYC - 12'h001)
                begin
                    dly_busy_r <= 1'b0;
                    ramp_start <= 1'b1;                                  // [R12]
                    vout_code  <= rv_min(target_r, {1'b0, ceil_r});      // [R5]
                end
            end
        end
    end

    // Low-output flag needs the condition unbroken for the hold time.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            low_cnt_r  <= '0;
            low_flag_r <= 1'b0;
        end
        else if (!fault_in.low)
        begin
            low_cnt_r  <= '0;
            low_flag_r <= 1'b0;
        end
        else if (low_cnt_r == rv_pkg::RV_LOW_HOLD_CYC - 12'h001)
            low_flag_r <= 1'b1;                                          // [R15]
        else
            low_cnt_r <= low_cnt_r + 12'h001;
    end

    // Sticky excess-current flag; a new event in the read cycle wins over the clear.
    always_ff @(posedge clock)
    begin
        if (rst)
            excess_r <= 1'b0;
        else if (fault_in.excess)
            excess_r <= 1'b1;                                            // [R8] [R18]
        else if (rd_load && (cmd_r == rv_pkg::RV_CMD_FLAGS))
            excess_r <= 1'b0;                                            // [R18]
    end

    // Current monitor snapshot; software sees a stable value between refreshes.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mon_cnt_r <= '0;
            curr_r    <= rv_pkg::RV_ZERO_BYTE;
        end
        else if (mon_cnt_r == rv_pkg::RV_MON_CYC - 12'h001)
        begin
            mon_cnt_r <= '0;
            curr_r    <= current_sample;                                 // [R13]
        end
        else
            mon_cnt_r <= mon_cnt_r + 12'h001;
    end

    // Open-drain pins: value fixed low, enable pulled low only to signal.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sda_out    <= 1'b0;
            alert_out  <= 1'b0;
            alert_oe_n <= 1'b1;
            ramp_rate  <= rv_pkg::RV_RAMP_RST;
        end
        else
        begin
            sda_out    <= 1'b0;
            alert_out  <= 1'b0;
            alert_oe_n <= ~summary;                                      // [R19]
            ramp_rate  <= ramp_r;                                        // [R11]
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    addr_nack_a: assert property ((state_r == rv_pkg::RV_ADDR) && ev.fall && byte_done // [R1]
        && (sh_r[7:1] != rv_pkg::RV_DEV_ADDR) |=> sda_oe_n)
        else $error("Foreign address was acknowledged.");
    start_delay_a: assert property (wr_now && (cmd_r == rv_pkg::RV_CMD_TARGET) // [R12]
        |-> !ramp_start ##1 (!ramp_start)[*5] ##1 ramp_start)
        else $error("Ramp start not 0.5 us after target acknowledge.");
    clamp_apply_a: assert property (ramp_start |-> vout_code <= {1'b0, ceil_r}) // [R5]
        else $error("Applied code exceeds ceiling.");
    flag_top_a: assert property ((cmd_r == rv_pkg::RV_CMD_FLAGS) // [R7]
        |-> (rd_data[7:6] == 2'b00))
        else $error("Unused flag bits read nonzero.");
    ceil_range_a: assert property (ceil_r >= rv_pkg::RV_CEIL_MIN[6:0] // [R4]
        && ceil_r <= rv_pkg::RV_CEIL_MAX[6:0])
        else $error("Ceiling code out of range.");
    low_hold_a: assert property ($rose(low_flag_r) |-> $past(fault_in.low) // [R15]
        && ($past(low_cnt_r) == rv_pkg::RV_LOW_HOLD_CYC - 12'h001))
        else $error("Low flag set without sustained condition.");
    alert_mask_a: assert property (mask_r[5:1] == 5'h1F |=> alert_oe_n) // [R9]
        else $error("Fully masked alert still driven.");
    alert_track_a: assert property (summary |=> !alert_oe_n) // [R10] [R19]
        else $error("Unmasked flag did not pull alert low.");
    excess_hold_a: assert property (fault_in.excess |=> excess_r) // [R18]
        else $error("Excess flag not captured.");
    mon_refresh_a: assert property ($changed(curr_r) // [R13]
        |-> $past(mon_cnt_r) == rv_pkg::RV_MON_CYC - 12'h001)
        else $error("Current value changed between refreshes.");

    write_seen_c: cover property (wr_now && (cmd_r == rv_pkg::RV_CMD_TARGET));
    read_seen_c: cover property (rd_load && (cmd_r == rv_pkg::RV_CMD_FLAGS));
    clamp_seen_c: cover property (ramp_start && ceil_viol);
    alert_seen_c: cover property (!alert_oe_n);
endmodule
`default_nettype wire

// ### dv/rv_host_model.sv
// Purpose: Serial bus host model that drives clock and data toward the register file.
// Assumes: Four system clocks per serial phase, changes one step after a clock edge.
// Notes:   Each ack bit or read byte is reported for one cycle on got and got_v.
`timescale 1ns/100ps
`default_nettype none
module rv_host_model (
    input  wire logic       clock, // System clock.
    input  wire logic       sda,   // Resolved data line.
    output logic            scl,   // Serial clock drive.
    output logic            sda_m, // Host data drive, 1 releases the line.
    output logic            got,   // One-cycle result strobe.
    output logic [7:0]      got_v  // Ack bit or read byte.
);
    // Idle bus is high on both lines.
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
        got = 1'b0;
        got_v = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Four clocks a phase stay clear of the two-clock minimum.
    task automatic pulse(output logic s);
        tick(4);
        scl = 1'b1;
        tick(2);
        s = sda;
        tick(2);
        scl = 1'b0;
    endtask
    // Bits go out most significant first, the ninth pulse carries the ack.
    task automatic byte_io(input logic [7:0] v, input logic rd);
        logic [7:0] r;
        logic a;
        for (int i = 7; i >= 0; i--)
        begin
            sda_m = rd | v[i];
            pulse(r[i]);
        end
        sda_m = 1'b1;
        pulse(a);
        got_v = rd ? r : {7'h00, a};
        got = 1'b1;
        tick(1);
        got = 1'b0;
    endtask
    // Start also serves as repeated start, since data rises before the clock.
    task automatic start();
        sda_m = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask
    // Write is address, command, data; read is command then repeated start.
    task automatic wr(input logic [6:0] a, input logic [7:0] c, d);
        start();
        byte_io({a, 1'b0}, 1'b0);
        byte_io(c, 1'b0);
        byte_io(d, 1'b0);
        stop();
    endtask
    task automatic rd(input logic [7:0] c);
        start();
        byte_io({rv_pkg::RV_DEV_ADDR, 1'b0}, 1'b0);
        byte_io(c, 1'b0);
        start();
        byte_io({rv_pkg::RV_DEV_ADDR, 1'b1}, 1'b0);
        byte_io(8'hFF, 1'b1);
        stop();
    endtask
endmodule
`default_nettype wire

// ### dv/rv_regfile_tb.sv
// Purpose: Self-checking bench for the regulator serial register file.
// Assumes: 10 MHz clock, host model on the serial pins.
// Notes:   Expected acks, bytes and ramp codes queue up and are checked as they appear.
`timescale 1ns/100ps
`default_nettype none
module rv_regfile_tb;
    logic clock, rst, scl, sda_m, sda, got, sda_out, sda_oe_n, alert_out, alert_oe_n, ramp_start;
    logic [7:0] got_v, cur, m, vout_code, ramp_rate, lfsr = 8'h62;
    logic [7:0] rq[$], vq[$];
    logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h51, 8'h00, 8'h00, 8'h00, 8'h04, 8'h33, 8'h00};
    rv_pkg::rv_fault_type flt;
    int fails = 0;
    int comparisons = 0;
    // Open-drain data line: anyone pulling low wins.
    assign sda = sda_m & (sda_oe_n | sda_out);
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    rv_host_model H (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m), .got(got), .got_v(got_v));
    rv_regfile DUT (.clock(clock), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .fault_in(flt), .current_sample(cur), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .vout_code(vout_code), .ramp_rate(ramp_rate),
        .ramp_start(ramp_start));
    task automatic cmp(input string n, input logic [7:0] e, v);
        comparisons++;
        if (v !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, v);
        end
    endtask
    // Results are matched against the oldest note as they appear.
    always @(posedge clock)
    begin
        if (got === 1'b1) cmp("bus", rq.size() ? rq.pop_front() : 8'hXX, got_v);
        if (ramp_start === 1'b1)
            cmp("vout", vq.size() ? vq.pop_front() : 8'hXX, vout_code);
    end
    task automatic w(input logic [7:0] c, d);
        repeat (3) rq.push_back(8'h00);
        H.wr(rv_pkg::RV_DEV_ADDR, c, d);
    endtask
    task automatic r(input logic [7:0] c, e);
        repeat (3) rq.push_back(8'h00);
        rq.push_back(e);
        H.rd(c);
    endtask
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic conclude();
        $display("counts comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial
    begin
        repeat (60000) @(posedge clock);
        fails++;
        conclude();
    end
    initial
    begin
        rst = 1'b1;
        flt = '0;
        cur = lfsr;
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        for (int i = 0; i < 9; i++) r(8'(i), rv[i]);
        cmp("ramp_rate", 8'h04, ramp_rate);
        $display("test reset values done");
        repeat (3) rq.push_back(8'h01);
        H.wr(7'h71, rv_pkg::RV_CMD_TARGET, 8'h10);
        w(8'h04, 8'hFF);
        w(8'h08, 8'hFF);
        w(8'h00, 8'hFF);
        r(8'h00, 8'h00);
        r(8'h07, 8'h33);
        $display("test address and reserved done");
        w(8'h02, 8'hFF);
        r(8'h02, 8'h7E);
        w(8'h02, 8'h00);
        r(8'h02, 8'h01);
        w(8'h02, 8'h40);
        vq.push_back(8'h40);
        w(8'h07, 8'h50);
        r(8'h04, 8'h03);
        cmp("alert", 8'h00, {6'h00, alert_out, alert_oe_n});
        vq.push_back(8'h30);
        w(8'h07, 8'h30);
        r(8'h04, 8'h00);
        cmp("alert", 8'h01, {7'h00, alert_oe_n});
        $display("test ceiling clamp done");
        for (int b = 2; b <= 5; b++)
        begin
            if (b == 4) continue;
            lfsr = nxt(lfsr);
            m = lfsr & 8'h3E;
            w(8'h05, lfsr);
            r(8'h05, m);
            flt = 4'(1 << (b - 2));
            H.tick(3);
            cmp("alert", {7'h00, m[b]}, {7'h00, alert_oe_n});
            r(8'h04, 8'(1 << b) | {7'h00, ~m[b]});
            flt = '0;
            r(8'h04, b == 2 ? 8'h04 : 8'h00);
            cmp("alert", 8'h01, {7'h00, alert_oe_n});
        end
        $display("test flags and mask done");
        lfsr = nxt(lfsr);
        w(8'h05, 8'hFF);
        flt = (lfsr[3:0] & 4'hA) | 4'h8;
        H.tick(3);
        cmp("alert", 8'h01, {7'h00, alert_oe_n});
        w(8'h05, 8'h00);
        flt = 4'h4;
        H.tick(1400);
        r(8'h04, 8'h00);
        H.tick(700);
        r(8'h04, 8'h11);
        flt = '0;
        r(8'h04, 8'h00);
        $display("test low hold done");
        lfsr = nxt(lfsr);
        cur = lfsr;
        w(8'h06, lfsr);
        r(8'h06, lfsr);
        cmp("ramp_rate", lfsr, ramp_rate);
        H.tick(4100);
        w(8'h08, 8'h00);
        r(8'h08, cur);
        $display("test monitor and ramp done");
        cmp("queue", 8'h00, 8'(rq.size() + vq.size()));
        conclude();
    end
endmodule
`default_nettype wire
